/* boot_reset_pkg.sv */
// Purpose: shared constants and carrier types for the boot/reset controller
// Assumes: 100 MHz core clock
// Notes:   all timing figures are given in their own units, cycles derived
`default_nettype none
package boot_reset_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned SUPPLY_WAIT_US = 100;
    // Least time, rounded up to whole cycles
    localparam int unsigned SUPPLY_WAIT_CYC =
        (SUPPLY_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAIT_W = 14;
    localparam logic [6:0] ADDR_PORT_A = 7'h38;
    localparam logic [6:0] ADDR_PORT_B = 7'h3F;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int unsigned STAT_CONNECTED_BIT = 0;

    // Per-port data-connection status, read over the target port
    typedef struct packed {
        logic [4:0] reserved;
        logic       companionMode;
        logic       dpMode;
        logic       connected;
    } port_status_t;

    // Outputs toward the external SBU mux
    typedef struct packed {
        logic pathSelectA;
        logic pathSelectB;
        logic auxEnable;
        logic lowspeedEnable;
    } mux_ctl_t;

    typedef enum logic [1:0] {
        FLASH_OWN_LOAD,
        FLASH_WAIT_SUPPLY,
        FLASH_COMPANION
    } flash_phase_t;
endpackage : boot_reset_pkg
`default_nettype wire

/* supply_wait_timer.sv */
// Purpose: counts the settle time after the companion supply turns good
// Assumes: supply-good is synchronous to core_clk
// Notes:   any drop of supply-good restarts the wait
`default_nettype none
module supply_wait_timer #(
    parameter int unsigned WAIT_CYC = boot_reset_pkg::SUPPLY_WAIT_CYC
) (
    input  wire logic core_clk,    // Core clock
    input  wire logic rst_n,       // Sync reset, active low
    input  wire logic clkEn,       // Freezes state when low
    input  wire logic supplyGood,  // Companion supply valid
    output logic      waitDone     // Supply valid for the full wait
);
    logic [boot_reset_pkg::WAIT_W-1:0] count_r, count_nxt;
    logic                              done_r, done_nxt;

    // Count only while supply holds; restart from zero on any drop
    always_comb begin
        count_nxt = count_r;
        done_nxt  = done_r;
        if (!supplyGood) begin
            count_nxt = '0;
            done_nxt  = 1'b0;
        end else if (!done_r) begin
            if (count_r == boot_reset_pkg::WAIT_W'(WAIT_CYC - 1)) begin
                done_nxt = 1'b1;
            end else begin
                count_nxt = count_r + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_r <= '0;
            done_r  <= 1'b0;
        end else if (clkEn) begin
            count_r <= count_nxt;
            done_r  <= done_nxt;
        end
    end

    assign waitDone = done_r;
endmodule : supply_wait_timer
`default_nettype wire

/* port_status_target.sv */
// Purpose: answers register reads for the two target addresses
// Assumes: the serial target engine presents a read pulse and the raw 7-bit address
// Notes:   the read strobe and address are taken on one edge
`default_nettype none
module port_status_target (
    input  wire logic                       core_clk,  // Core clock
    input  wire logic                       rst_n,     // Sync reset
    input  wire logic                       clkEn,     // Clock enable
    input  wire logic                       rdReq,     // Read request pulse
    input  wire logic [6:0]                 rdAddr,    // 7-bit target address
    input  wire boot_reset_pkg::port_status_t stA,     // Port A status
    input  wire boot_reset_pkg::port_status_t stB,     // Port B status
    output logic                            rdAck,     // Address matched
    output logic                            rdNack,    // Address unknown
    output logic [7:0]                      rdData     // Returned status
);
    logic       ack_r, ack_nxt, nack_r, nack_nxt;
    logic [7:0] data_r, data_nxt;

    // Each address maps to exactly one port; others are refused
    always_comb begin
        ack_nxt  = 1'b0;
        nack_nxt = 1'b0;
        data_nxt = data_r;
        if (rdReq) begin
            unique case (rdAddr)
                boot_reset_pkg::ADDR_PORT_A: begin
                    ack_nxt  = 1'b1;
                    data_nxt = stA;
                end
                boot_reset_pkg::ADDR_PORT_B: begin
                    ack_nxt  = 1'b1;
                    data_nxt = stB;
                end
                default: begin
                    nack_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_r  <= 1'b0;
            nack_r <= 1'b0;
            data_r <= boot_reset_pkg::STATUS_RESET;
        end else if (clkEn) begin
            ack_r  <= ack_nxt;
            nack_r <= nack_nxt;
            data_r <= data_nxt;
        end
    end

    assign rdAck  = ack_r;
    assign rdNack = nack_r;
    assign rdData = data_r;
endmodule : port_status_target
`default_nettype wire

/* shared_flash_boot_reset_ctl.sv */
// Purpose: shared flash turn-taking, companion reset, status and SBU mux
// Assumes: all inputs synchronous to core_clk
// Notes:   reset output is an ordinary push-pull level on pin zero
// Notes on behaviour
// - The device loads its configuration first; the companion uses the flash only after.
// - Companion reset stays asserted until the configuration load is finished.
// - Pin zero is only the active-low companion reset output.
// - Reset is released no sooner than 100 us after companion supply is good.
// - The target port serves both addresses 0x38 and 0x3F.
// - Address 0x38 returns port A status and 0x3F returns port B status.
// - A port connection raises the shared interrupt and its status is readable.
// - Port 0 orientation drives both mux path selects together.
// - Port 0 display mode drives the aux enable, companion mode the low-speed one.
// - Primary port is controller to the SoC, secondary is target to the EC.
`default_nettype none
module shared_flash_boot_reset_ctl #(
    parameter int unsigned WAIT_CYC = boot_reset_pkg::SUPPLY_WAIT_CYC
) (
    input  wire logic        core_clk,        // 100 MHz core clock
    input  wire logic        rst_n,           // Sync reset, active low
    input  wire logic        clkEn,           // Freezes all state when low
    input  wire logic        configLoadDone,  // Own config read finished
    input  wire logic        companionSupplyGood, // Companion 3.3 V valid
    input  wire logic        bootHoldEn,      // EC wants release after boot
    input  wire logic        systemBooted,    // EC: system booted
    input  wire logic        rdReq,           // Target read request pulse
    input  wire logic [6:0]  rdAddr,          // Target address
    input  wire logic [1:0]  portConnected,   // Per-port connection
    input  wire logic [1:0]  portDpMode,      // Per-port display mode
    input  wire logic [1:0]  portCompanionMode, // Per-port companion mode
    input  wire logic        port0Flipped,    // Port 0 plug orientation
    input  wire logic        intAck,          // Companion has read status
    output logic             companionResetLine_n, // Pin zero reset out
    output logic             flashOwnedByDevice, // Device owns flash
    output logic             flashGrantCompanion, // Companion may use flash
    output logic             secondaryIntr_n, // Shared interrupt, low active
    output logic             rdAck,           // Read answered
    output logic             rdNack,          // Address refused
    output logic [7:0]       rdData,          // Status byte
    output boot_reset_pkg::mux_ctl_t muxCtl,  // SBU mux controls
    output logic             primaryIsController, // Primary port role
    output logic             secondaryIsTarget    // Secondary port role
);
    boot_reset_pkg::flash_phase_t phase_r, phase_nxt;
    logic rstLine_r, rstLine_nxt;
    logic own_r, own_nxt, grant_r, grant_nxt;
    logic waitDone;
    boot_reset_pkg::port_status_t stA, stB;
    logic [1:0] connPrev_r, connPrev_nxt;
    logic intPend_r, intPend_nxt;
    boot_reset_pkg::mux_ctl_t mux_r, mux_nxt;
    logic roles_r;

    supply_wait_timer #(.WAIT_CYC(WAIT_CYC)) u_wait (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .supplyGood(companionSupplyGood),
        .waitDone  (waitDone)
    );

    // Flash ownership and reset release sequence
    always_comb begin
        phase_nxt   = phase_r;
        rstLine_nxt = 1'b0;
        own_nxt     = 1'b1;
        grant_nxt   = 1'b0;
        unique case (phase_r)
            boot_reset_pkg::FLASH_OWN_LOAD: begin
                if (configLoadDone) begin
                    phase_nxt = boot_reset_pkg::FLASH_WAIT_SUPPLY;
                end
            end
            boot_reset_pkg::FLASH_WAIT_SUPPLY: begin
                own_nxt = 1'b0;
                // Release needs supply settled and, if asked, boot done
                if (waitDone && (!bootHoldEn || systemBooted)) begin
                    phase_nxt   = boot_reset_pkg::FLASH_COMPANION;
                    rstLine_nxt = 1'b1;
                    grant_nxt   = 1'b1;
                end
            end
            boot_reset_pkg::FLASH_COMPANION: begin
                own_nxt = 1'b0;
                // Supply loss puts the companion back into reset
                if (!companionSupplyGood) begin
                    phase_nxt = boot_reset_pkg::FLASH_WAIT_SUPPLY;
                end else begin
                    rstLine_nxt = 1'b1;
                    grant_nxt   = 1'b1;
                end
            end
        endcase
    end

    // Reset value low keeps the companion held with no release glitch
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase_r   <= boot_reset_pkg::FLASH_OWN_LOAD;
            rstLine_r <= 1'b0;
            own_r     <= 1'b1;
            grant_r   <= 1'b0;
        end else if (clkEn) begin
            phase_r   <= phase_nxt;
            rstLine_r <= rstLine_nxt;
            own_r     <= own_nxt;
            grant_r   <= grant_nxt;
        end
    end

    // Status bytes served over the target port
    always_comb begin
        stA = '0;
        stB = '0;
        stA.connected     = portConnected[0];
        stA.dpMode        = portDpMode[0];
        stA.companionMode = portCompanionMode[0];
        stB.connected     = portConnected[1];
        stB.dpMode        = portDpMode[1];
        stB.companionMode = portCompanionMode[1];
    end

    port_status_target u_tgt (
        .core_clk(core_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .rdReq   (rdReq),
        .rdAddr  (rdAddr),
        .stA     (stA),
        .stB     (stB),
        .rdAck   (rdAck),
        .rdNack  (rdNack),
        .rdData  (rdData)
    );

    // Any new connection raises the interrupt; set wins over ack
    always_comb begin
        connPrev_nxt = portConnected;
        intPend_nxt  = intPend_r;
        if (intAck) begin
            intPend_nxt = 1'b0;
        end
        if (|(portConnected & ~connPrev_r)) begin
            intPend_nxt = 1'b1;
        end
    end

    // Mux follows port 0 events; both selects move as one
    always_comb begin
        mux_nxt.pathSelectA    = port0Flipped;
        mux_nxt.pathSelectB    = port0Flipped;
        mux_nxt.auxEnable      = portConnected[0] & portDpMode[0];
        mux_nxt.lowspeedEnable = portConnected[0]
                                 & portCompanionMode[0];
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            connPrev_r <= 2'h0;
            intPend_r  <= 1'b0;
            mux_r      <= '0;
            roles_r    <= 1'b0;
        end else if (clkEn) begin
            connPrev_r <= connPrev_nxt;
            intPend_r  <= intPend_nxt;
            mux_r      <= mux_nxt;
            roles_r    <= 1'b1;
        end
    end

    assign companionResetLine_n = rstLine_r;
    assign flashOwnedByDevice   = own_r;
    assign flashGrantCompanion  = grant_r;
    assign secondaryIntr_n      = ~intPend_r;
    assign muxCtl               = mux_r;
    assign primaryIsController  = roles_r;
    assign secondaryIsTarget    = roles_r;

    // Release only after load and a settled supply
    property p_no_early_release;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(companionResetLine_n) |-> waitDone && !own_r;
    endproperty
    a_no_early_release: assert property (p_no_early_release)
        else $error("companion reset released too early");

    property p_held_until_load;
        @(posedge core_clk) disable iff (!rst_n)
        own_r |-> !companionResetLine_n;
    endproperty
    a_held_until_load: assert property (p_held_until_load)
        else $error("reset released while device owns flash");

    property p_no_shared_flash;
        @(posedge core_clk) disable iff (!rst_n)
        !(flashOwnedByDevice && flashGrantCompanion);
    endproperty
    a_no_shared_flash: assert property (p_no_shared_flash)
        else $error("flash used by both parties");

    property p_reset_low_after_rst;
        @(posedge core_clk) $past(!rst_n) |-> !companionResetLine_n;
    endproperty
    a_reset_low_after_rst: assert property (p_reset_low_after_rst)
        else $error("reset line not low after reset");

    property p_ack_port_a;
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && rdReq && rdAddr == boot_reset_pkg::ADDR_PORT_A
        |=> rdAck && rdData == $past(stA);
    endproperty
    a_ack_port_a: assert property (p_ack_port_a)
        else $error("port A address not served");

    property p_ack_port_b;
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && rdReq && rdAddr == boot_reset_pkg::ADDR_PORT_B
        |=> rdAck && rdData == $past(stB);
    endproperty
    a_ack_port_b: assert property (p_ack_port_b)
        else $error("port B address not served");

    sequence s_new_conn;
        clkEn && |(portConnected & ~connPrev_r);
    endsequence
    property p_conn_intr;
        @(posedge core_clk) disable iff (!rst_n)
        s_new_conn |=> !secondaryIntr_n;
    endproperty
    a_conn_intr: assert property (p_conn_intr)
        else $error("connection did not raise interrupt");

    property p_select_pair;
        @(posedge core_clk) disable iff (!rst_n)
        clkEn |=> muxCtl.pathSelectA == $past(port0Flipped)
               && muxCtl.pathSelectB == muxCtl.pathSelectA;
    endproperty
    a_select_pair: assert property (p_select_pair)
        else $error("mux selects not tracking orientation");

    property p_enables;
        @(posedge core_clk) disable iff (!rst_n)
        clkEn |=> muxCtl.auxEnable ==
                  $past(portConnected[0] & portDpMode[0])
               && muxCtl.lowspeedEnable ==
                  $past(portConnected[0] & portCompanionMode[0]);
    endproperty
    a_enables: assert property (p_enables)
        else $error("mux enables wrong");
endmodule : shared_flash_boot_reset_ctl
`default_nettype wire

/* companion_partner_model.sv */
// Purpose: companion controller, EC and board gate on the far side
// Assumes: one byte per read request, answer one edge after it is taken
// Notes:   address lines show the inverse value once released
`default_nettype none
module companion_partner_model (
    input  wire logic       core_clk,     // Core clock
    input  wire logic       svcEn,        // Service interrupts when high
    input  wire logic       resetLine_n,  // Reset from pin zero
    input  wire logic       supplyGood,   // Companion supply valid
    input  wire logic       grant,        // Flash handed to companion
    input  wire logic       intrN,        // Shared interrupt, low active
    input  wire logic       ack,          // Read answered
    input  wire logic [7:0] data,         // Read byte
    output logic            req,          // Read request pulse
    output logic [6:0]      addr,         // Target address
    output logic            intAck,       // Status consumed
    output logic            gatedReset_n, // Reset after board gate
    output logic [7:0]      lastA,        // Last port A byte
    output logic [7:0]      lastB,        // Last port B byte
    output logic            badFetch      // Running without the flash
);
    timeunit 1ns;
    timeprecision 1ns;

    // Board gate keeps the companion in reset while it is unpowered
    assign gatedReset_n = resetLine_n & supplyGood;
    // A running companion fetches firmware, so it must hold the grant
    assign badFetch = gatedReset_n & ~grant;

    // Idle levels at time zero
    initial begin
        req = 1'b0;
        addr = 7'h00;
        intAck = 1'b0;
        lastA = 8'h00;
        lastB = 8'h00;
    end

    // One read: request for one edge; the registered answer stands for
    // the cycle after that edge, so it is taken at the next falling edge
    task automatic readAddr(input logic [6:0] a, output logic gotAck,
                            output logic [7:0] got);
        @(negedge core_clk);
        req = 1'b1;
        addr = a;
        @(negedge core_clk);
        gotAck = ack;
        got = data;
        req = 1'b0;
        addr = ~a; // Released lines must not keep the old value
    endtask : readAddr

    // Either port may have changed, so both addresses are read
    always @(negedge core_clk) begin : svc
        logic       k;
        logic [7:0] d;
        if (svcEn && intrN === 1'b0) begin
            readAddr(boot_reset_pkg::ADDR_PORT_A, k, d);
            lastA = d;
            readAddr(boot_reset_pkg::ADDR_PORT_B, k, d);
            lastB = d;
            @(negedge core_clk);
            intAck = 1'b1;
            @(negedge core_clk);
            intAck = 1'b0;
        end
    end
endmodule : companion_partner_model
`default_nettype wire

/* shared_flash_boot_reset_ctl_bench.sv */
// Purpose: self-checking bench for the boot/reset controller
// Assumes: inputs change on the falling edge, outputs read there too
// Notes:   supply wait shortened to 8 cycles to keep the run short
`default_nettype none
module shared_flash_boot_reset_ctl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned WAITC = 8;
    logic core_clk, rst_n, clkEn, configLoadDone, supplyGood;
    logic bootHoldEn, systemBooted, rdReq, port0Flipped, intAck, svcEn;
    logic [6:0] rdAddr;
    logic [1:0] portConnected, portDpMode, portCompanionMode;
    logic rstLine_n, owned, grant, intrN, rdAck, rdNack, roleP, roleS;
    logic gated_n, badFetch;
    logic [7:0] rdData, lastA, lastB;
    boot_reset_pkg::mux_ctl_t muxCtl;
    int check_count = 0;
    int n_mismatch = 0;

    shared_flash_boot_reset_ctl #(.WAIT_CYC(WAITC))
        u_shared_flash_boot_reset_ctl (
        .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
        .configLoadDone(configLoadDone), .companionSupplyGood(supplyGood),
        .bootHoldEn(bootHoldEn), .systemBooted(systemBooted),
        .rdReq(rdReq), .rdAddr(rdAddr), .portConnected(portConnected),
        .portDpMode(portDpMode), .portCompanionMode(portCompanionMode),
        .port0Flipped(port0Flipped), .intAck(intAck),
        .companionResetLine_n(rstLine_n), .flashOwnedByDevice(owned),
        .flashGrantCompanion(grant), .secondaryIntr_n(intrN),
        .rdAck(rdAck), .rdNack(rdNack), .rdData(rdData), .muxCtl(muxCtl),
        .primaryIsController(roleP), .secondaryIsTarget(roleS));

    companion_partner_model u_companion_partner_model (
        .core_clk(core_clk), .svcEn(svcEn), .resetLine_n(rstLine_n),
        .supplyGood(supplyGood), .grant(grant), .intrN(intrN),
        .ack(rdAck), .data(rdData), .req(rdReq), .addr(rdAddr),
        .intAck(intAck), .gatedReset_n(gated_n), .lastA(lastA),
        .lastB(lastB), .badFetch(badFetch));

    // Free-running 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic nc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : nc

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // Bounded wait for release; too late or too early both count
    task automatic waitRel(input int lo, input int hi);
        int n;
        n = 0;
        while (rstLine_n !== 1'b1 && n <= hi) begin
            nc(1);
            n++;
        end
        check("release delay", 8'(n >= lo && n <= hi), 8'h01);
        if (n > hi) tally_and_finish();
    endtask : waitRel

    task automatic waitIntrClear;
        int n;
        n = 0;
        while (intrN !== 1'b1 && n < 40) begin
            nc(1);
            n++;
        end
        check("interrupt cleared", intrN, 8'h01);
        if (n >= 40) tally_and_finish();
    endtask : waitIntrClear

    task automatic t_reset;
        nc(4);
        check("reset line", rstLine_n, 8'h00);
        check("flash owned", owned, 8'h01);
        check("grant", grant, 8'h00);
        check("mux", {4'h0, muxCtl}, 8'h00);
        rst_n = 1'b1;
        nc(2);
        check("roles", {roleP, roleS}, 8'h03);
        $display("done t_reset");
    endtask : t_reset

    // Supply is long good, but release waits for the own load
    task automatic t_boot;
        nc(3 * WAITC);
        check("reset held", rstLine_n, 8'h00);
        check("owned held", owned, 8'h01);
        configLoadDone = 1'b1;
        // Taken at the next edge, ownership falls one edge after that
        nc(2);
        check("owned dropped", owned, 8'h00);
        waitRel(0, 3);
        check("grant given", grant, 8'h01);
        check("no early fetch", badFetch, 8'h00);
        $display("done t_boot");
    endtask : t_boot

    // A glitch on supply-good must restart the full wait
    task automatic t_supply;
        supplyGood = 1'b0;
        nc(1);
        check("reset on drop", rstLine_n, 8'h00);
        check("grant on drop", grant, 8'h00);
        nc(5);
        supplyGood = 1'b1;
        nc(3);
        supplyGood = 1'b0;
        nc(1);
        supplyGood = 1'b1;
        waitRel(WAITC, WAITC + 4);
        check("gated out", gated_n, 8'h01);
        $display("done t_supply");
    endtask : t_supply

    task automatic t_hold;
        bootHoldEn = 1'b1;
        systemBooted = 1'b0;
        supplyGood = 1'b0;
        nc(2);
        supplyGood = 1'b1;
        nc(3 * WAITC);
        check("held for boot", rstLine_n, 8'h00);
        systemBooted = 1'b1;
        waitRel(0, 3);
        bootHoldEn = 1'b0;
        $display("done t_hold");
    endtask : t_hold

    // Both port addresses answer; 0x38's neighbours and the ends 0x00 and 0x7F are refused
    task automatic t_reads;
        logic [6:0] ad [6] = '{7'h38, 7'h3F, 7'h39, 7'h37, 7'h00, 7'h7F};
        logic [7:0] ed [2] = '{8'h02, 8'h04};
        logic       k;
        logic [7:0] d;
        svcEn = 1'b0;
        for (int i = 0; i < 6; i++) begin
            u_companion_partner_model.readAddr(ad[i], k, d);
            check("ack", k, 8'(i < 2));
            check("nack", rdNack, 8'(i >= 2));
            check("data", d, ed[i < 2 ? i : 1]);
        end
        $display("done t_reads");
    endtask : t_reads

    task automatic t_intr;
        svcEn = 1'b1;
        portConnected = 2'b10;
        nc(1);
        check("intr for B", intrN, 8'h00);
        waitIntrClear();
        check("B status", lastB, 8'h05);
        check("A status", lastA, 8'h02);
        portConnected = 2'b11;
        nc(1);
        check("intr for A", intrN, 8'h00);
        waitIntrClear();
        check("A connected", lastA, 8'h03);
        $display("done t_intr");
    endtask : t_intr

    // Every orientation and mode mix, then loss of connection and freeze
    task automatic t_mux;
        logic [2:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            port0Flipped = v[2];
            portDpMode = {portDpMode[1], v[1]};
            portCompanionMode = {portCompanionMode[1], v[0]};
            nc(1);
            check("mux", {4'h0, muxCtl}, {4'h0, v[2], v});
        end
        portConnected = 2'b10;
        nc(1);
        check("mux unplugged", {4'h0, muxCtl}, 8'h0C);
        clkEn = 1'b0;
        port0Flipped = 1'b0;
        nc(3);
        check("mux frozen", {4'h0, muxCtl}, 8'h0C);
        clkEn = 1'b1;
        nc(1);
        check("mux resumed", {4'h0, muxCtl}, 8'h00);
        $display("done t_mux");
    endtask : t_mux

    // Main sequence
    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        configLoadDone = 1'b0;
        supplyGood = 1'b1;
        bootHoldEn = 1'b0;
        systemBooted = 1'b0;
        portConnected = 2'b00;
        portDpMode = 2'b01;
        portCompanionMode = 2'b10;
        port0Flipped = 1'b0;
        svcEn = 1'b0;
        t_reset();
        t_boot();
        t_supply();
        t_hold();
        t_reads();
        t_intr();
        t_mux();
        tally_and_finish();
    end
endmodule : shared_flash_boot_reset_ctl_bench
`default_nettype wire
